// *** core/wadj_defines.vh ***
// constants for the wiper adjust block and its nonvolatile word map
`ifndef WADJ_DEFINES_VH
`define WADJ_DEFINES_VH

// ==========================================
// frame layout
`define WADJ_FRAME_BITS 24
`define WADJ_CNT_W 5
`define WADJ_CMD_MSB 23
`define WADJ_CMD_LSB 20
`define WADJ_ADR_MSB 19
`define WADJ_ADR_LSB 16
`define WADJ_DAT_MSB 15
`define WADJ_DAT_LSB 0
`define WADJ_CHSEL_BIT 16

// ==========================================
// command codes
`define WADJ_OP_NOP 4'h0
`define WADJ_OP_RESTORE 4'h1
`define WADJ_OP_SAVE_WIPER 4'h2
`define WADJ_OP_WRITE_NV 4'h3
`define WADJ_OP_SHR_ONE 4'h4
`define WADJ_OP_SHR_ALL 4'h5
`define WADJ_OP_DEC_ONE 4'h6
`define WADJ_OP_DEC_ALL 4'h7
`define WADJ_OP_RESTORE_ALL 4'h8
`define WADJ_OP_READ_NV 4'h9
`define WADJ_OP_READ_WIPER 4'hA
`define WADJ_OP_WRITE_WIPER 4'hB
`define WADJ_OP_SHL_ONE 4'hC
`define WADJ_OP_SHL_ALL 4'hD
`define WADJ_OP_INC_ONE 4'hE
`define WADJ_OP_INC_ALL 4'hF

// ==========================================
// nonvolatile word map
`define WADJ_NV_SAVED_CH1 4'h0
`define WADJ_NV_SAVED_CH2 4'h1
`define WADJ_NV_SPARE_FIRST 4'h2
`define WADJ_NV_SPARE_SECOND 4'h3
`define WADJ_NV_SPARE_LAST 4'hE
`define WADJ_NV_TOLERANCE 4'hF
`define WADJ_NV_RESET 16'h0000

// ==========================================
// tolerance word fields
`define WADJ_TOL_SIGN_BIT 15
`define WADJ_TOL_INT_MSB 14
`define WADJ_TOL_INT_LSB 8
`define WADJ_TOL_FRAC_MSB 7
`define WADJ_TOL_FRAC_LSB 0

// ==========================================
// wiper codes
`define WADJ_WIPER_ZERO 10'h000
`define WADJ_WIPER_ONE 10'h001
`define WADJ_WIPER_MID 10'h200
`define WADJ_WIPER_FULL 10'h3FF

`endif

// *** core/wadj_tap_decode.v ***
// one-hot tap switch decoder for one wiper channel
`timescale 1ns/1ps

module wadj_tap_decode #(
  parameter CODE_W = 10,
  parameter TAPS = 1024
)(
  core_clk,
  rst,
  code,
  tap_switch_r,
  bottom_terminal_switch
);
  input wire core_clk;
  input wire rst;
  input wire [CODE_W-1:0] code;
  output reg [TAPS-1:0] tap_switch_r;
  output wire bottom_terminal_switch;

  // ==========================================
  // tap decode
  // bottom terminal is never opened
  assign bottom_terminal_switch = 1'b1; // R21

  genvar i;
  generate
    for (i = 0; i < TAPS; i = i + 1)
    begin : g_tap
      // exactly one tap closed; reset closes tap zero
      always @(posedge core_clk)
      begin
        if (rst)
          tap_switch_r[i] <= (i == 0);
        else
          tap_switch_r[i] <= (code == i[CODE_W-1:0]); // R21
      end
    end
  endgenerate

endmodule // wadj_tap_decode

// *** core/wadj_top.v ***
// wiper setting registers, adjust commands, nonvolatile word map and serial frame port
//
// Summary of operation
// R1: single-channel increment raises the selected wiper by one code.
// R2: ganged increment raises both wipers by one code together.
// R3: decrements lower one or both wipers by one, holding at zero.
// R4: increments hold at all ones instead of wrapping.
// R5: 6 dB step-up exists for one channel and for both together.
// R6: 6 dB step-down exists for one channel and for both together.
// R7: step-up shifts toward MSB, step-down shifts toward LSB.
// R8: step-up from zero loads code one.
// R9: step-up from midscale or above loads full scale.
// R10: step-up at full scale leaves the wiper unchanged.
// R11: step-down inserts zero at MSB, drops LSB, stays at zero.
// R12: a bare chip-select strobe repeats the previous command.
// R13: commands execute only when chip select returns high.
// R14: adjust commands ignore the frame data bytes.
// R15: store has 4-bit address: two saved wipers, thirteen spares, tolerance.
// R16: spare words hold full 16-bit values written and read back.
// R17: saved wipers load the wipers at power-on, restore, reset command, preset pin.
// R18: tolerance word is read-only; user writes are ignored.
// R19: tolerance bit 15 is sign, 0 negative, 1 positive.
// R20: tolerance bits 14..8 integer percent, bits 7..0 fraction in 256ths.
// R21: exactly one of 1024 taps on, bottom terminal switch always on.
`timescale 1ns/1ps
`include "wadj_defines.vh"

module wadj_top #(
  parameter CODE_W = 10,
  parameter TAPS = 1024,
  parameter NV_WORDS = 16,
  parameter [15:0] TOLERANCE_WORD = 16'h8000
)(
  core_clk,
  rst,
  cs_n,
  sclk,
  sdi,
  sdo,
  preset_restore_pin_n,
  wiper_ch1_r,
  wiper_ch2_r,
  tap_ch1_r,
  tap_ch2_r,
  bottom_terminal_switch_ch1,
  bottom_terminal_switch_ch2,
  tol_positive,
  tol_int_percent,
  tol_frac_256ths
);
  input wire core_clk;
  input wire rst;
  input wire cs_n;
  input wire sclk;
  input wire sdi;
  output wire sdo;
  input wire preset_restore_pin_n;
  output reg [CODE_W-1:0] wiper_ch1_r;
  output reg [CODE_W-1:0] wiper_ch2_r;
  output wire [TAPS-1:0] tap_ch1_r;
  output wire [TAPS-1:0] tap_ch2_r;
  output wire bottom_terminal_switch_ch1;
  output wire bottom_terminal_switch_ch2;
  output wire tol_positive;
  output wire [6:0] tol_int_percent;
  output wire [7:0] tol_frac_256ths;

  // ==========================================
  // serial frame capture
  reg sclk_prev_r;
  reg cs_prev_r;
  reg [`WADJ_FRAME_BITS-1:0] shift_r;
  reg [`WADJ_FRAME_BITS-1:0] shift_nxt;
  reg [`WADJ_CNT_W-1:0] bit_cnt_r;
  reg [`WADJ_FRAME_BITS-1:0] last_frame_r;
  reg por_pend_r;
  reg [15:0] nv_store_r [0:NV_WORDS-1];

  wire sclk_rise;
  wire frame_end;
  wire frame_full;
  wire frame_bare;
  wire exec_go;
  wire [`WADJ_FRAME_BITS-1:0] exec_frame;
  wire [3:0] op;
  wire [3:0] adr;
  wire [15:0] dat;
  wire chsel;

  assign sclk_rise = sclk & ~sclk_prev_r & ~cs_n;
  // the command waits for the strobe's trailing edge
  assign frame_end = cs_n & ~cs_prev_r; // R13
  assign frame_full = (bit_cnt_r == `WADJ_FRAME_BITS);
  assign frame_bare = (bit_cnt_r == {`WADJ_CNT_W{1'b0}});
  // partial frames are dropped rather than guessed at
  assign exec_go = frame_end & (frame_full | frame_bare);
  // a strobe with no clocks replays the last good frame
  assign exec_frame = frame_bare ? last_frame_r : shift_r; // R12
  assign op = exec_frame[`WADJ_CMD_MSB:`WADJ_CMD_LSB];
  assign adr = exec_frame[`WADJ_ADR_MSB:`WADJ_ADR_LSB];
  assign dat = exec_frame[`WADJ_DAT_MSB:`WADJ_DAT_LSB];
  assign chsel = exec_frame[`WADJ_CHSEL_BIT];

  // daisy-chain output is the oldest bit held
  assign sdo = shift_r[`WADJ_FRAME_BITS-1];

  // edge history of the serial pins
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end
    else
    begin
      sclk_prev_r <= sclk;
      cs_prev_r <= cs_n;
    end
  end

  // bit counter saturates one past a full frame so overlong frames are dropped
  always @(posedge core_clk)
  begin
    if (rst)
      bit_cnt_r <= {`WADJ_CNT_W{1'b0}};
    else if (frame_end)
      bit_cnt_r <= {`WADJ_CNT_W{1'b0}};
    else if (sclk_rise && bit_cnt_r <= `WADJ_FRAME_BITS)
      bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  // ==========================================
  // wiper step arithmetic
  // one function covers every adjust op so both channels share it
  function [CODE_W-1:0] step_wiper;
    input [3:0] f_op;
    input [CODE_W-1:0] w;
    begin
      step_wiper = w;
      case (f_op)
        `WADJ_OP_INC_ONE, `WADJ_OP_INC_ALL:
        begin
          if (w != `WADJ_WIPER_FULL)
            step_wiper = w + 10'h001; // R1 R2 R4
        end
        `WADJ_OP_DEC_ONE, `WADJ_OP_DEC_ALL:
        begin
          if (w != `WADJ_WIPER_ZERO)
            step_wiper = w - 10'h001; // R3
        end
        `WADJ_OP_SHL_ONE, `WADJ_OP_SHL_ALL:
        begin
          if (w == `WADJ_WIPER_ZERO)
            step_wiper = `WADJ_WIPER_ONE; // R8
          else if (w >= `WADJ_WIPER_MID)
            step_wiper = `WADJ_WIPER_FULL; // R9 R10
          else
            step_wiper = {w[CODE_W-2:0], 1'b0}; // R5 R7
        end
        `WADJ_OP_SHR_ONE, `WADJ_OP_SHR_ALL:
          step_wiper = {1'b0, w[CODE_W-1:1]}; // R6 R7 R11
        default:
          step_wiper = w;
      endcase
    end
  endfunction

  // ==========================================
  // command decode
  reg hit_ch1;
  reg hit_ch2;
  reg is_adjust;
  reg do_restore1;
  reg do_restore2;

  // which channels a command touches; adjust ops see no frame data
  always @*
  begin
    hit_ch1 = 1'b0;
    hit_ch2 = 1'b0;
    is_adjust = 1'b0;
    do_restore1 = por_pend_r | ~preset_restore_pin_n; // R17
    do_restore2 = por_pend_r | ~preset_restore_pin_n; // R17
    if (exec_go)
    begin
      case (op)
        `WADJ_OP_INC_ALL, `WADJ_OP_DEC_ALL, `WADJ_OP_SHL_ALL, `WADJ_OP_SHR_ALL:
        begin
          is_adjust = 1'b1; // R14
          hit_ch1 = 1'b1; // R2
          hit_ch2 = 1'b1;
        end
        `WADJ_OP_INC_ONE, `WADJ_OP_DEC_ONE, `WADJ_OP_SHL_ONE, `WADJ_OP_SHR_ONE:
        begin
          is_adjust = 1'b1; // R14
          hit_ch1 = ~chsel; // R1
          hit_ch2 = chsel;
        end
        `WADJ_OP_RESTORE:
        begin
          do_restore1 = do_restore1 | ~chsel; // R17
          do_restore2 = do_restore2 | chsel;
        end
        `WADJ_OP_RESTORE_ALL:
        begin
          do_restore1 = 1'b1; // R17
          do_restore2 = 1'b1;
        end
        default:
          is_adjust = 1'b0;
      endcase
    end
  end

  // ==========================================
  // wiper setting registers
  // restore wins over a serial command landing in the same cycle
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      wiper_ch1_r <= `WADJ_WIPER_ZERO;
      wiper_ch2_r <= `WADJ_WIPER_ZERO;
    end
    else
    begin
      if (do_restore1)
        wiper_ch1_r <= nv_store_r[`WADJ_NV_SAVED_CH1][CODE_W-1:0]; // R17
      else if (is_adjust && hit_ch1)
        wiper_ch1_r <= step_wiper(op, wiper_ch1_r);
      else if (exec_go && op == `WADJ_OP_WRITE_WIPER && !chsel)
        wiper_ch1_r <= dat[CODE_W-1:0];
      if (do_restore2)
        wiper_ch2_r <= nv_store_r[`WADJ_NV_SAVED_CH2][CODE_W-1:0]; // R17
      else if (is_adjust && hit_ch2)
        wiper_ch2_r <= step_wiper(op, wiper_ch2_r);
      else if (exec_go && op == `WADJ_OP_WRITE_WIPER && chsel)
        wiper_ch2_r <= dat[CODE_W-1:0];
    end
  end

  // power-on refresh one cycle after reset release
  always @(posedge core_clk)
  begin
    if (rst)
      por_pend_r <= 1'b1;
    else
      por_pend_r <= 1'b0; // R17
  end

  // ==========================================
  // nonvolatile word store
  // no write timing is modelled; a write lands at the strobe edge
  genvar g;
  generate
    for (g = 0; g < NV_WORDS; g = g + 1)
    begin : g_nv
      if (g == `WADJ_NV_TOLERANCE)
      begin : g_tol
        // factory value only, never written by the user
        always @(posedge core_clk)
        begin
          nv_store_r[g] <= TOLERANCE_WORD; // R18
        end
      end
      else
      begin : g_rw
        always @(posedge core_clk)
        begin
          if (rst)
            nv_store_r[g] <= `WADJ_NV_RESET;
          else if (exec_go && op == `WADJ_OP_WRITE_NV && adr == g)
            nv_store_r[g] <= dat; // R15 R16
          else if (exec_go && op == `WADJ_OP_SAVE_WIPER && g == {3'h0, chsel})
            nv_store_r[g] <= {6'h00, (chsel ? wiper_ch2_r : wiper_ch1_r)};
        end
      end
    end
  endgenerate

  // tolerance fields: sign, integer percent, fraction
  assign tol_positive = nv_store_r[`WADJ_NV_TOLERANCE][`WADJ_TOL_SIGN_BIT]; // R19
  assign tol_int_percent = nv_store_r[`WADJ_NV_TOLERANCE][`WADJ_TOL_INT_MSB:`WADJ_TOL_INT_LSB]; // R20
  assign tol_frac_256ths = nv_store_r[`WADJ_NV_TOLERANCE][`WADJ_TOL_FRAC_MSB:`WADJ_TOL_FRAC_LSB]; // R20

  // ==========================================
  // shift register and readback
  // a read command replaces the data bytes so the next frame carries them out
  always @*
  begin
    shift_nxt = shift_r;
    if (sclk_rise)
      shift_nxt = {shift_r[`WADJ_FRAME_BITS-2:0], sdi};
    else if (exec_go && op == `WADJ_OP_READ_NV)
      shift_nxt = {exec_frame[`WADJ_CMD_MSB:`WADJ_ADR_LSB], nv_store_r[adr]}; // R15
    else if (exec_go && op == `WADJ_OP_READ_WIPER)
      shift_nxt = {exec_frame[`WADJ_CMD_MSB:`WADJ_ADR_LSB], 6'h00, (chsel ? wiper_ch2_r : wiper_ch1_r)};
  end

  always @(posedge core_clk)
  begin
    if (rst)
      shift_r <= {`WADJ_FRAME_BITS{1'b0}};
    else
      shift_r <= shift_nxt;
  end

  // remember the last complete frame for replay
  always @(posedge core_clk)
  begin
    if (rst)
      last_frame_r <= {`WADJ_FRAME_BITS{1'b0}};
    else if (frame_end && frame_full)
      last_frame_r <= shift_r; // R12
  end

  // ==========================================
  // tap switch decoders
  wadj_tap_decode #(
    .CODE_W(CODE_W),
    .TAPS(TAPS)
  ) u_tap_ch1 (
    .core_clk(core_clk),
    .rst(rst),
    .code(wiper_ch1_r),
    .tap_switch_r(tap_ch1_r),
    .bottom_terminal_switch(bottom_terminal_switch_ch1)
  );

  wadj_tap_decode #(
    .CODE_W(CODE_W),
    .TAPS(TAPS)
  ) u_tap_ch2 (
    .core_clk(core_clk),
    .rst(rst),
    .code(wiper_ch2_r),
    .tap_switch_r(tap_ch2_r),
    .bottom_terminal_switch(bottom_terminal_switch_ch2)
  );

endmodule // wadj_top

// *** verification/wadj_top_sva.sv ***
// port-level assertion checker for the wiper adjust block
`timescale 1ns/1ps
module wadj_top_sva #(
  parameter CODE_W = 10,
  parameter TAPS = 1024,
  parameter [15:0] TOLERANCE_WORD = 16'h8000
)(
  input wire core_clk,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire sdo,
  input wire preset_restore_pin_n,
  input wire [CODE_W-1:0] wiper_ch1_r,
  input wire [CODE_W-1:0] wiper_ch2_r,
  input wire [TAPS-1:0] tap_ch1_r,
  input wire [TAPS-1:0] tap_ch2_r,
  input wire bottom_terminal_switch_ch1,
  input wire bottom_terminal_switch_ch2,
  input wire tol_positive,
  input wire [6:0] tol_int_percent,
  input wire [7:0] tol_frac_256ths
);
  // ==========================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff rst;
  // wipers move only on a strobe rise, the preset pin or the refresh after reset
  wiper_one_hold_a: assert property (!$stable(wiper_ch1_r) |-> ($past(cs_n) && !$past(cs_n, 2))
    || !$past(preset_restore_pin_n) || $past(rst) || $past(rst, 2)) else $error("wiper 1 moved mid frame");
  wiper_two_hold_a: assert property (!$stable(wiper_ch2_r) |-> ($past(cs_n) && !$past(cs_n, 2))
    || !$past(preset_restore_pin_n) || $past(rst) || $past(rst, 2)) else $error("wiper 2 moved mid frame");
  // sdo shifts on a taken bit or reloads on the strobe rise, never otherwise
  sdo_moves_a: assert property ($changed(sdo) |-> ($past(sclk) && !$past(sclk, 2) && !$past(cs_n))
    || ($past(cs_n) && !$past(cs_n, 2)) || $past(rst)) else $error("sdo moved without a bit");
  preset_hold_a: assert property (!preset_restore_pin_n [*2] |=> $stable(wiper_ch1_r) && $stable(wiper_ch2_r))
    else $error("wipers not held by preset");
  tap_onehot_a: assert property ($onehot(tap_ch1_r) && $onehot(tap_ch2_r))
    else $error("tap switches not one hot");
  tap_follows_a: assert property (tap_ch1_r[$past(wiper_ch1_r)] && tap_ch2_r[$past(wiper_ch2_r)])
    else $error("tap switch does not follow wiper");
  bottom_on_a: assert property (bottom_terminal_switch_ch1 && bottom_terminal_switch_ch2)
    else $error("bottom switch off");
  tol_fields_a: assert property ({tol_positive, tol_int_percent, tol_frac_256ths} == TOLERANCE_WORD)
    else $error("tolerance fields wrong");
  frame_end_c: cover property ($rose(cs_n));
  preset_c: cover property ($fell(preset_restore_pin_n));
  full_scale_c: cover property (&wiper_ch1_r);
endmodule // wadj_top_sva

bind wadj_top wadj_top_sva #(.CODE_W(CODE_W), .TAPS(TAPS), .TOLERANCE_WORD(TOLERANCE_WORD)) wadj_top_sva_inst (
  .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdo(sdo),
  .preset_restore_pin_n(preset_restore_pin_n), .wiper_ch1_r(wiper_ch1_r), .wiper_ch2_r(wiper_ch2_r),
  .tap_ch1_r(tap_ch1_r), .tap_ch2_r(tap_ch2_r), .bottom_terminal_switch_ch1(bottom_terminal_switch_ch1),
  .bottom_terminal_switch_ch2(bottom_terminal_switch_ch2), .tol_positive(tol_positive),
  .tol_int_percent(tol_int_percent), .tol_frac_256ths(tol_frac_256ths));

// *** verification/wadj_spi_master.sv ***
// serial master model that shifts frames into the wiper block
`timescale 1ns/1ps
module wadj_spi_master (
  input wire core_clk,
  output reg cs_n,
  output reg sclk,
  output reg sdi,
  input wire sdo
);
  // ==========================================
  // idle: strobe high, clock parked low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // n bits msb first, sdo captured before each shift; n of 0 gives a bare strobe
  task frame(input int n, input logic [23:0] w, output logic [23:0] r);
    int i;
    begin
      r = 24'h000000;
      @(posedge core_clk) #1 cs_n = 1'b0;
      @(posedge core_clk) #1;
      for (i = 0; i < n; i++)
      begin
        sdi = w[23 - i];
        r = {r[22:0], sdo};
        @(posedge core_clk) #1 sclk = 1'b1;
        @(posedge core_clk) #1 sclk = 1'b0;
      end
      cs_n = 1'b1;
      sdi = ~sdi; // idle data flips so a stale bit is never trusted
      @(posedge core_clk);
      @(posedge core_clk) #1;
    end
  endtask
endmodule // wadj_spi_master

// *** verification/tb.sv ***
// self-checking bench for the wiper adjust block
`timescale 1ns/1ps
`include "wadj_defines.vh"
`define WADJ_CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
  localparam [15:0] TOL = 16'h9C0F;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg preset_restore_pin_n = 1'b1;
  wire cs_n, sclk, sdi, sdo, bsw1, bsw2, tol_positive;
  wire [9:0] wiper_ch1_r, wiper_ch2_r;
  wire [1023:0] tap_ch1_r, tap_ch2_r;
  wire [6:0] tol_int_percent;
  wire [7:0] tol_frac_256ths;
  logic [9:0] ew [2];
  logic [15:0] env [16];
  logic [23:0] last, rx, f;
  logic [3:0] ops [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF, 4'hB};
  logic [9:0] edge_codes [5] = '{10'h000, 10'h001, 10'h1FF, 10'h200, 10'h3FF};
  logic [23:0] corner [8] = '{24'hB003FF, 24'hE00000, 24'hC00000, 24'hB00000, 24'hC00000, 24'h600000,
    24'hB00200, 24'hD00000};
  int error_cnt = 0;
  int total_checks = 0;
  int i;
  wadj_top #(.TOLERANCE_WORD(TOL)) wadj_top_inst (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .preset_restore_pin_n(preset_restore_pin_n), .wiper_ch1_r(wiper_ch1_r),
    .wiper_ch2_r(wiper_ch2_r), .tap_ch1_r(tap_ch1_r), .tap_ch2_r(tap_ch2_r), .bottom_terminal_switch_ch1(bsw1),
    .bottom_terminal_switch_ch2(bsw2), .tol_positive(tol_positive), .tol_int_percent(tol_int_percent),
    .tol_frac_256ths(tol_frac_256ths));
  wadj_spi_master wadj_spi_master_inst (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  // ==========================================
  // expected wiper after one adjust or write
  function automatic logic [9:0] step(input logic [3:0] op, input logic [9:0] w, input logic [9:0] d);
    case (op)
      `WADJ_OP_SHR_ONE, `WADJ_OP_SHR_ALL: step = w >> 1;
      `WADJ_OP_DEC_ONE, `WADJ_OP_DEC_ALL: step = (w == 10'h000) ? w : w - 10'h001;
      `WADJ_OP_SHL_ONE, `WADJ_OP_SHL_ALL: step = (w == 10'h000) ? 10'h001 : (w >= 10'h200) ? 10'h3FF : w << 1;
      `WADJ_OP_INC_ONE, `WADJ_OP_INC_ALL: step = (&w) ? w : w + 10'h001;
      `WADJ_OP_WRITE_WIPER: step = d;
      default: step = w;
    endcase
  endfunction
  // expected state after a complete frame; ganged adjusts have bits 2 and 0 of the opcode set
  task automatic apply(input logic [23:0] fr);
    logic [3:0] op;
    int c;
    begin
      op = fr[23:20];
      c = fr[16];
      if (op[2] && op[0])
      begin
        ew[0] = step(op, ew[0], fr[9:0]);
        ew[1] = step(op, ew[1], fr[9:0]);
      end
      else if (op == `WADJ_OP_RESTORE)
        ew[c] = env[c][9:0];
      else if (op == `WADJ_OP_RESTORE_ALL)
        ew = '{env[0][9:0], env[1][9:0]};
      else if (op == `WADJ_OP_SAVE_WIPER)
        env[c] = {6'h00, ew[c]};
      else if (op == `WADJ_OP_WRITE_NV && fr[19:16] != `WADJ_NV_TOLERANCE)
        env[fr[19:16]] = fr[15:0];
      else
        ew[c] = step(op, ew[c], fr[9:0]);
    end
  endtask
  task check;
    begin
      `WADJ_CHK("wiper_ch1", ew[0], wiper_ch1_r)
      `WADJ_CHK("wiper_ch2", ew[1], wiper_ch2_r)
      // taps trail the wiper by one cycle, settled by the time a send returns
      `WADJ_CHK("tap_ch1", 1'b1, tap_ch1_r[ew[0]])
      `WADJ_CHK("tap_ch2", 1'b1, tap_ch2_r[ew[1]])
    end
  endtask
  // one frame of n bits; only whole frames count, a bare strobe replays the last one
  task automatic send(input int n, input logic [23:0] fr);
    begin
      wadj_spi_master_inst.frame(n, fr, rx);
      if (n == 24)
        last = fr;
      if (n == 24 || n == 0)
        apply(n == 0 ? last : fr);
      check();
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // watchdog well past the roughly 18000 cycles of traffic
  initial
  begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(53));
    ew = '{10'h000, 10'h000};
    for (i = 0; i < 16; i++)
      env[i] = 16'h0000;
    env[15] = TOL;
    last = 24'h000000;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check();
    `WADJ_CHK("tol_sign", TOL[15], tol_positive)
    `WADJ_CHK("tol_int", TOL[14:8], tol_int_percent)
    `WADJ_CHK("tol_frac", TOL[7:0], tol_frac_256ths)
    `WADJ_CHK("bottom", 2'b11, {bsw1, bsw2})
    $display("test reset done");
    for (i = 0; i < 8; i++)
      send(24, corner[i]);
    send(24, 24'hF00000);
    repeat (11) send(24, 24'h500000);
    // both wipers now sit at zero, so decrements must hold there
    send(24, 24'h700000);
    send(24, 24'h610000);
    $display("test corners done");
    for (i = 0; i < 300; i++)
    begin
      f = {ops[$urandom % 9], 3'b000, 1'($urandom), 16'($urandom)};
      if (f[23:20] == `WADJ_OP_WRITE_WIPER && $urandom % 2)
        f[9:0] = edge_codes[$urandom % 5];
      if ($urandom % 8 == 0)
        send(0, f);
      else if ($urandom % 16 == 0)
        send(1 + $urandom % 23, f);
      else
        send(24, f);
    end
    $display("test random adjust done");
    send(24, 24'h200000);
    send(24, 24'h210000);
    send(24, {12'hB00, 2'b00, 10'($urandom)});
    send(24, 24'h100000);
    send(24, {12'hB10, 2'b00, 10'($urandom)});
    send(24, 24'h800000);
    send(24, {12'hB00, 2'b00, 10'($urandom)});
    preset_restore_pin_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 preset_restore_pin_n = 1'b1;
    ew = '{env[0][9:0], env[1][9:0]};
    check();
    // wiper readback: the next frame carries the restored setting out on sdo
    for (i = 0; i < 2; i++)
    begin
      send(24, {4'hA, 3'h0, 1'(i), 16'($urandom)});
      send(24, 24'h000000);
      `WADJ_CHK("wiper_read", {4'hA, 3'h0, 1'(i), 6'h00, ew[i]}, rx)
    end
    $display("test restore done");
    for (i = 2; i < 16; i++)
      send(24, {4'h3, 4'(i), 16'($urandom)});
    for (i = 0; i < 16; i++)
    begin
      send(24, {4'h9, 4'(i), 16'h0000});
      send(24, 24'h000000);
      `WADJ_CHK("nv_read", {4'h9, 4'(i), env[i]}, rx)
    end
    $display("test store done");
    report_and_stop();
  end
endmodule // tb
